// *** logic/ppt_target.sv ***
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppt_params.svh"

module ppt_target (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire ppt_pkg::ppt_apb_req_t apb_req,
  output var  ppt_pkg::ppt_apb_rsp_t apb_rsp,
  output var  ppt_pkg::ppt_ext_t     ext_port
);
  import ppt_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [`PPT_TGT_BITS-1:0] target_q;
  logic [`PPT_TGT_BITS-1:0] target_d;
  ppt_func_t                func_q;
  ppt_func_t                func_d;
  logic                     pready_q;
  logic                     pslverr_q;
  logic                     pready_d;
  logic                     pslverr_d;
  logic [31:0]              prdata_q;
  logic [31:0]              prdata_d;
  ppt_ext_t                 ext_q;
  ppt_ext_t                 ext_d;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so every bus
  // output comes straight from a flop
  wire access      = apb_req.psel & apb_req.penable & ~pready_q;
  wire wr          = access & apb_req.pwrite;
  wire rd          = access & ~apb_req.pwrite;
  wire [11:0] adr  = apb_req.paddr;

  wire hit_tgt     = (adr == `PPT_OFS_TARGET);
  wire hit_clr     = (adr == `PPT_OFS_TARGET_CLR);
  wire hit_set     = (adr == `PPT_OFS_TARGET_SET);
  wire hit_inv     = (adr == `PPT_OFS_TARGET_INV);
  wire hit_ctl     = (adr == `PPT_OFS_CONTROL);
  wire hit_sts     = (adr == `PPT_OFS_STATUS);
  wire hit_any     = hit_tgt | hit_clr | hit_set | hit_inv | hit_ctl | hit_sts;

  // status is read-only; writing it is an error like an unmapped word
  wire bad_access  = ~hit_any | (apb_req.pwrite & hit_sts);

  // upper half of the write word is dropped on purpose
  wire [`PPT_TGT_BITS-1:0] wlow = apb_req.pwdata[`PPT_TGT_BITS-1:0];

  wire do_wr_tgt   = wr & hit_tgt;
  wire do_wr_clr   = wr & hit_clr;
  wire do_wr_set   = wr & hit_set;
  wire do_wr_inv   = wr & hit_inv;
  wire do_wr_ctl   = wr & hit_ctl;

  // --------------------------------------------------------------------------
  // bus response
  // --------------------------------------------------------------------------
  // the error flag only ever rides on the ready pulse, never on its own
  assign pready_d  = access;
  assign pslverr_d = access & bad_access;

  // --------------------------------------------------------------------------
  // target register, per-bit update
  // --------------------------------------------------------------------------
  // the clear, set and invert aliases let software touch one select line
  // without a read-modify-write that could race another writer
  genvar gi;
  generate
    for (gi = 0; gi < `PPT_TGT_BITS; gi = gi + 1) begin : g_bit
      wire bit_q = target_q[gi];
      wire bit_w = wlow[gi];
      assign target_d[gi] = do_wr_tgt ? bit_w :
                            do_wr_clr ? (bit_q & ~bit_w) :
                            do_wr_set ? (bit_q | bit_w) :
                            do_wr_inv ? (bit_q ^ bit_w) :
                            bit_q;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  wire [1:0] func_w = apb_req.pwdata[`PPT_CTL_FUNC_MSB:`PPT_CTL_FUNC_LSB];

  assign func_d = do_wr_ctl ? ppt_func_t'(func_w) : func_q;

  // --------------------------------------------------------------------------
  // function decode
  // --------------------------------------------------------------------------
  wire mode_addr16 = (func_q == PPT_FUNC_ADDR16);
  wire mode_one    = (func_q == PPT_FUNC_ONE_SEL);
  wire mode_two    = (func_q == PPT_FUNC_TWO_SEL);

  // a top bit serving as a select leaves its address line low
  wire top_is_sel  = mode_two | mode_one;
  wire top_is_addr = mode_addr16;
  wire mid_is_sel  = mode_two;
  wire mid_is_addr = mode_addr16 | mode_one;

  wire bit15       = target_q[`PPT_TGT_SEL2_BIT];
  wire bit14       = target_q[`PPT_TGT_SEL1_BIT];

  // --------------------------------------------------------------------------
  // external port drive
  // --------------------------------------------------------------------------
  // reserved function 11: both top bits drive nothing, safest for the bus
  assign ext_d.addr[`PPT_TGT_LOW_MSB:0] = target_q[`PPT_TGT_LOW_MSB:0];
  assign ext_d.addr[`PPT_TGT_SEL2_BIT]  = top_is_addr & bit15;
  assign ext_d.addr[`PPT_TGT_SEL1_BIT]  = mid_is_addr & bit14;
  assign ext_d.second_chip_select       = top_is_sel & bit15;
  assign ext_d.first_chip_select        = mid_is_sel & bit14;

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  logic [31:0] rd_tgt;
  logic [31:0] rd_ctl;
  logic [31:0] rd_sts;

  always_comb begin
    rd_tgt = 32'h0000_0000;
    rd_tgt[`PPT_TGT_BITS-1:0] = target_q;
  end

  always_comb begin
    rd_ctl = 32'h0000_0000;
    rd_ctl[`PPT_CTL_FUNC_MSB:`PPT_CTL_FUNC_LSB] = func_q;
  end

  // status shows what is on the pins now, one cycle behind the registers
  always_comb begin
    rd_sts = 32'h0000_0000;
    rd_sts[`PPT_TGT_BITS-1:0]    = ext_q.addr;
    rd_sts[`PPT_STS_SEL1_BIT]    = ext_q.first_chip_select;
    rd_sts[`PPT_STS_SEL2_BIT]    = ext_q.second_chip_select;
  end

  // aliases read back the target itself
  wire hit_tgt_any = hit_tgt | hit_clr | hit_set | hit_inv;

  // unmapped reads give zero beside the error flag
  always_comb begin
    if (!rd) begin
      prdata_d = prdata_q;
    end else if (hit_tgt_any) begin
      prdata_d = rd_tgt;
    end else if (hit_ctl) begin
      prdata_d = rd_ctl;
    end else if (hit_sts) begin
      prdata_d = rd_sts;
    end else begin
      prdata_d = 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // flops
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      target_q <= `PPT_TARGET_RST;
    end else begin
      target_q <= target_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      func_q <= ppt_func_t'(`PPT_FUNC_RST);
    end else begin
      func_q <= func_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // read data holds between reads so a late sampler still sees the word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // one cycle of pin latency keeps the pins off the decode path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_q <= '0;
    end else begin
      ext_q <= ext_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign apb_rsp.prdata  = prdata_q;
  assign ext_port        = ext_q;

endmodule : ppt_target

`default_nettype wire

// *** shared/ppt_params.svh ***
`ifndef PPT_PARAMS_SVH
`define PPT_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, aligned words)
// ----------------------------------------------------------------------------
`define PPT_OFS_TARGET      12'h000
`define PPT_OFS_TARGET_CLR  12'h004
`define PPT_OFS_TARGET_SET  12'h008
`define PPT_OFS_TARGET_INV  12'h00c
`define PPT_OFS_CONTROL     12'h010
`define PPT_OFS_STATUS      12'h014

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define PPT_TGT_BITS        16
`define PPT_TGT_SEL2_BIT    15
`define PPT_TGT_SEL1_BIT    14
`define PPT_TGT_LOW_MSB     13
`define PPT_CTL_FUNC_LSB    6
`define PPT_CTL_FUNC_MSB    7
`define PPT_STS_SEL1_BIT    16
`define PPT_STS_SEL2_BIT    17

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PPT_TARGET_RST      16'h0000
`define PPT_FUNC_RST        2'h0

`endif

// *** shared/ppt_pkg.sv ***
package ppt_pkg;

  // --------------------------------------------------------------------------
  // bus carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ppt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ppt_apb_rsp_t;

  // --------------------------------------------------------------------------
  // external port carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic        first_chip_select;
    logic        second_chip_select;
  } ppt_ext_t;

  // select_function_field encodings
  typedef enum logic [1:0] {
    PPT_FUNC_ADDR16   = 2'h0,
    PPT_FUNC_ONE_SEL  = 2'h1,
    PPT_FUNC_TWO_SEL  = 2'h2,
    PPT_FUNC_RESERVED = 2'h3
  } ppt_func_t;

endpackage : ppt_pkg

// *** bench/ppt_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppt_props (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire ppt_pkg::ppt_apb_req_t apb_req,
  input wire ppt_pkg::ppt_apb_rsp_t apb_rsp,
  input wire ppt_pkg::ppt_ext_t     ext_port
);
  import ppt_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire rd_done = apb_rsp.pready && !apb_req.pwrite;
  one_wait_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready not after one wait");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");
  err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr without pready");
  sel2_addr_a: assert property (ext_port.second_chip_select |-> !ext_port.addr[15])
    else $error("addr 15 driven while second select");
  sel1_addr_a: assert property (ext_port.first_chip_select |-> ext_port.addr[15:14] == 2'h0)
    else $error("addr 15..14 driven while first select");
  ext_hold_a: assert property (!$stable(ext_port) |-> $past(apb_rsp.pready && apb_req.pwrite))
    else $error("ext port moved without a write");
  upper_zero_a: assert property (rd_done && apb_req.paddr == 12'h000 |-> apb_rsp.prdata[31:16] == 16'h0)
    else $error("upper target bits not zero");
  low_addr_a: assert property (rd_done && apb_req.paddr == 12'h000 |-> apb_rsp.prdata[13:0] == ext_port.addr[13:0])
    else $error("low address lines differ from target");
endmodule : ppt_props
bind ppt_target ppt_props u_props (.core_clk(core_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ext_port(ext_port));
`default_nettype wire

// *** bench/ppt_periph.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppt_periph (
  input  wire logic              core_clk,
  input  wire ppt_pkg::ppt_ext_t ext_port,
  output var  logic [15:0]       latched_q
);
  import ppt_pkg::*;
  // a deselected memory ignores the lines, so only latch while selected
  always_ff @(posedge core_clk) begin
    if (ext_port.first_chip_select || ext_port.second_chip_select) begin
      latched_q <= ext_port.addr;
    end
  end
endmodule : ppt_periph
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppt_pkg::*;
  typedef struct packed { logic [1:0] f; logic [31:0] w; logic [17:0] x; } ppt_row_t;
  logic         core_clk, nrst;
  ppt_apb_req_t apb_req;
  ppt_apb_rsp_t apb_rsp;
  ppt_ext_t     ext_port;
  wire [15:0]   latched;
  wire [17:0]   ext_seen = {ext_port.second_chip_select, ext_port.first_chip_select, ext_port.addr};
  int           n_fail, cmp_count;
  logic [31:0]  rd;
  logic         err;
  // x is {second select, first select, addr}
  ppt_row_t     rows [6] = '{'{2'h0, 32'hffffc123, 18'h0c123}, '{2'h1, 32'h0000c123, 18'h24123},
    '{2'h2, 32'h0000c123, 18'h30123}, '{2'h3, 32'h0000c123, 18'h00123},
    '{2'h2, 32'h00003fff, 18'h03fff}, '{2'h1, 32'h00008000, 18'h20000}};
  ppt_target u_dut (.core_clk(core_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_port(ext_port));
  ppt_periph u_mem (.core_clk(core_clk), .ext_port(ext_port), .latched_q(latched));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // leading edge keeps a new setup off the edge that released the last one
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #2000000;
    n_fail++;
    print_verdict();
  end
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    apb_req = '0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    chk("ext reset", 32'h0, {14'h0, ext_port});
    foreach (rows[i]) begin
      apb(1'b1, 12'h010, {24'h0, rows[i].f, 6'h0});
      apb(1'b1, 12'h000, rows[i].w);
      apb(1'b0, 12'h000, 32'h0);
      chk("target", {16'h0, rows[i].w[15:0]}, rd);
      chk("ext port", {14'h0, rows[i].x}, {14'h0, ext_seen});
    end
    chk("periph latch", 32'h0, {16'h0, latched});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h008, 32'h00004000);
    apb(1'b0, 12'h014, 32'h0);
    chk("status", 32'h00024000, rd);
    apb(1'b1, 12'h004, 32'h00008000);
    apb(1'b0, 12'h00c, 32'h0);
    chk("clr alias", 32'h00004000, rd);
    apb(1'b1, 12'h00c, 32'h0000ffff);
    apb(1'b1, 12'h014, 32'hffffffff);
    chk("status wr err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h000, 32'h0);
    chk("inv alias", 32'h0000bfff, rd);
    chk("periph latch2", 32'h00003fff, {16'h0, latched});
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    chk("ext rereset", 32'h0, {14'h0, ext_port});
    apb(1'b0, 12'h000, 32'h0);
    chk("target rereset", 32'h0, rd);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
